// ==== design/pin_sync.sv ====
// three-stage synchroniser with agreement filter for a bundle of pins
// assumes each bit is an independent level from outside the sys_clk_i domain
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 28
) (
    input  wire logic         sys_clk_i,
    input  wire logic         sys_rst_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } sync_state_t;

    sync_state_t st_q;
    sync_state_t st_d;

    always_comb
    begin
        st_d    = st_q;
        st_d.s1 = async_i;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        // a bit only moves once stages two and three agree
        st_d.q  = (~(st_q.s2 ^ st_q.s3) & st_q.s3) | ((st_q.s2 ^ st_q.s3) & st_q.q);
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign sync_o = st_q.q;
endmodule

// ==== design/video_test_pattern_generator.sv ====
// video test pattern generator core: registers, timing, patterns, output pipe
// assumes a serial-control slave on sys_clk_i drives the register port
`timescale 1ns/1ps
module video_test_pattern_generator
    import vtpg_pkg::*;
(
    input  wire logic       sys_clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       power_down_i,
    input  wire logic       pixel_clk_i,
    input  wire logic       data_enable_i,
    input  wire logic       horizontal_sync_i,
    input  wire logic       vertical_sync_i,
    input  wire logic [7:0] red_i,
    input  wire logic [7:0] green_i,
    input  wire logic [7:0] blue_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_write_i,
    input  wire logic       reg_read_i,
    output logic      [7:0] reg_rdata_o,
    output logic            pixel_stb_o,
    output logic            data_enable_o,
    output logic            horizontal_sync_o,
    output logic            vertical_sync_o,
    output logic      [7:0] red_o,
    output logic      [7:0] green_o,
    output logic      [7:0] blue_o
);
    typedef struct packed {
        logic [7:0]       ctl;
        logic [7:0]       cfg;
        logic [7:0]       cr;
        logic [7:0]       cg;
        logic [7:0]       cb;
        logic [7:0]       tsc;
        logic [7:0][7:0]  ord;
        logic [7:0]       ia;
        logic [15:0][7:0] ind;
        logic [7:0]       rdata;
        logic             pclk_prev;
        logic [7:0]       div;
        logic             stb;
        logic [11:0]      ih;
        logic [11:0]      iv;
        logic             de1;
        logic             hs1;
        logic             vs1;
        logic             de2;
        logic             hs2;
        logic             vs2;
        logic [23:0]      rgb1;
        logic [23:0]      rgb2;
        logic [11:0]      x;
        logic [11:0]      y;
        logic [11:0]      wid;
        logic [11:0]      hgt;
        logic [12:0]      run;
        logic             vb_done;
        logic [3:0]       sidx;
    } gen_state_t;

    gen_state_t  st_q;
    gen_state_t  st_d;
    logic [27:0] sy;
    logic        tick;
    logic        fe;
    logic        run_hit;
    logic        active;
    logic        scroll;
    logic [1:0]  tmode;
    logic [4:0]  cur_pat;
    logic [11:0] hact;
    logic [11:0] vact;
    logic [11:0] htot;
    logic [11:0] vtot;
    logic        src_de;
    logic        src_hs;
    logic        src_vs;
    logic [11:0] wdiv;
    logic [11:0] hdiv;
    logic [7:0]  hl;
    logic [7:0]  vl;
    logic [2:0]  bar;
    logic [23:0] chkc;
    logic [23:0] pix;

    // ------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------
    pin_sync #(.W(28)) u_sync (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .async_i   ({pixel_clk_i, data_enable_i, horizontal_sync_i, vertical_sync_i,
                     red_i, green_i, blue_i}),
        .sync_o    (sy)
    );

    // ------------------------------------------------------------
    // pattern colour for one pixel
    // ------------------------------------------------------------
    function automatic logic [23:0] pat_rgb(input logic [4:0] p, input logic [7:0] h, input logic [7:0] v,
                                            input logic [2:0] b, input logic [1:0] vc, input logic ck,
                                            input logic [23:0] cust, input logic [23:0] chk);
        logic [7:0]  lv;
        logic [23:0] c;
        lv = (p < PAT_VR_GRAY) ? h : v;
        case (p)
            PAT_WHITE:                c = COL_WHITE;
            PAT_RED:                  c = {8'hff, 16'h0000};
            PAT_GREEN:                c = {8'h00, 8'hff, 8'h00};
            PAT_BLUE:                 c = {16'h0000, 8'hff};
            PAT_HR_GRAY, PAT_VR_GRAY: c = {lv, lv, lv};
            PAT_HR_RED, PAT_VR_RED:   c = {lv, 16'h0000};
            PAT_HR_GRN, PAT_VR_GRN:   c = {8'h00, lv, 8'h00};
            PAT_HR_BLU, PAT_VR_BLU:   c = {16'h0000, lv};
            PAT_CUSTOM:               c = cust;
            PAT_CHECK:                c = ck ? chk : COL_BLACK;
            PAT_VCOM:                 c = VCOM_COLORS[vc];
            PAT_BARS:                 c = BAR_COLORS[b];
            default:                  c = COL_BLACK;
        endcase
        return c;
    endfunction

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        st_d   = st_q;
        tmode  = st_q.cfg[CFG_TM_HI:CFG_TM_LO];
        active = st_q.cfg[CFG_EN] & ~power_down_i;
        scroll = st_q.cfg[CFG_SCR];
        // pixel rate: sampled pin clock or divided system clock
        st_d.pclk_prev = sy[27];
        if (tmode == TM_INT_OSC)
        begin
            tick     = st_q.div == st_q.ind[IX_OSC_DIV];
            st_d.div = tick ? 8'h00 : st_q.div + 8'h01;
        end
        else
        begin
            tick     = sy[27] & ~st_q.pclk_prev;
            st_d.div = 8'h00;
        end
        st_d.stb = tick;
        // internal timing generator
        hact   = {st_q.ind[IX_HACT_HI][3:0], st_q.ind[IX_HACT_LO]};
        vact   = {st_q.ind[IX_VACT_HI][3:0], st_q.ind[IX_VACT_LO]};
        htot   = 12'(hact + st_q.ind[IX_HBLK]);
        vtot   = 12'(vact + st_q.ind[IX_VBLK]);
        if (tmode == TM_EXT)
        begin
            src_de = sy[26];
            src_hs = sy[25];
            src_vs = sy[24];
        end
        else
        begin
            src_de = (st_q.ih < hact) && (st_q.iv < vact);
            src_hs = (st_q.ih >= hact) && (st_q.ih < 12'(hact + st_q.ind[IX_HSW]));
            src_vs = (st_q.iv >= vact) && (st_q.iv < 12'(vact + st_q.ind[IX_VSW]));
        end
        // frame end: sync edge, or a blank run reaching twice the measured active width
        run_hit = ~src_de && (st_q.wid != 12'h000) && (st_q.run == {1'b0, st_q.wid} + {1'b0, st_q.wid});
        fe      = tick && !st_q.vb_done && ((src_vs && !st_q.vs1) || run_hit);
        // ramp scaling from measured size
        wdiv = (st_q.wid == 12'h000) ? 12'h001 : st_q.wid;
        hdiv = (st_q.hgt == 12'h000) ? 12'h001 : st_q.hgt;
        hl   = 8'((20'(st_q.x) * RAMP_TOP) / 20'(wdiv));
        vl   = 8'((20'(st_q.y) * RAMP_TOP) / 20'(hdiv));
        bar  = 3'((15'(st_q.x) * BAR_COUNT) / 15'(wdiv));
        // nibble entries map to patterns 1..16, so bars cannot be scrolled
        cur_pat = scroll ? 5'({1'b0, st_q.ord[st_q.sidx[3:1]] >> {st_q.sidx[0], 2'b00}} & 5'h0f) + 5'h01
                         : st_q.ctl[CTL_PAT_HI:0];
        chkc    = st_q.ctl[CTL_CKC] ? {st_q.cr, st_q.cg, st_q.cb} : COL_WHITE;
        pix     = pat_rgb(cur_pat, hl, vl, bar,
                          st_q.x[1:0] ^ {2{st_q.ctl[CTL_VCF]}},
                          st_q.x[CHK_BIT] ^ st_q.y[CHK_BIT],
                          {st_q.cr, st_q.cg, st_q.cb}, chkc);
        if (st_q.ctl[CTL_INV])
            pix = ~pix;
        if (st_q.cfg[CFG_GINV])
            pix = ~pix;
        if (st_q.cfg[CFG_B18])
            pix = pix & {MASK_18, MASK_18, MASK_18};
        if (tick)
        begin
            if (st_q.ih >= 12'(htot - 12'h001))
            begin
                st_d.ih = 12'h000;
                st_d.iv = (st_q.iv >= 12'(vtot - 12'h001)) ? 12'h000 : st_q.iv + 12'h001;
            end
            else
                st_d.ih = st_q.ih + 12'h001;
            // two-stage control and pixel pipe
            st_d.de1  = src_de;
            st_d.hs1  = src_hs;
            st_d.vs1  = src_vs;
            st_d.de2  = st_q.de1;
            st_d.hs2  = st_q.hs1;
            st_d.vs2  = st_q.vs1;
            st_d.rgb1 = active ? pix : sy[23:0];
            st_d.rgb2 = st_q.rgb1;
            // frame geometry measurement
            if (src_de)
            begin
                st_d.x       = st_q.x + 12'h001;
                st_d.run     = 13'h0000;
                st_d.vb_done = 1'b0;
            end
            else
            begin
                st_d.run = (st_q.run == 13'h1fff) ? st_q.run : st_q.run + 13'h0001;
                if (st_q.de1)
                begin
                    st_d.wid = st_q.x;
                    st_d.x   = 12'h000;
                    st_d.y   = st_q.y + 12'h001;
                end
            end
            if (fe)
            begin
                st_d.hgt     = st_q.y;
                st_d.y       = 12'h000;
                st_d.x       = 12'h000;
                st_d.vb_done = 1'b1;
                if (scroll)
                    st_d.sidx = (st_q.sidx >= st_q.tsc[3:0]) ? 4'h0 : st_q.sidx + 4'h1;
            end
        end
        if (!scroll)
            st_d.sidx = 4'h0;
        if (power_down_i)
        begin
            st_d.de2  = 1'b0;
            st_d.hs2  = 1'b0;
            st_d.vs2  = 1'b0;
            st_d.rgb2 = COL_BLACK;
        end
        // register port
        if (reg_write_i)
        begin
            unique case (reg_addr_i)
                ADDR_CTL:   st_d.ctl = reg_wdata_i;
                ADDR_CFG:   st_d.cfg = reg_wdata_i;
                ADDR_RED:   st_d.cr  = reg_wdata_i;
                ADDR_GRN:   st_d.cg  = reg_wdata_i;
                ADDR_BLU:   st_d.cb  = reg_wdata_i;
                ADDR_TSC:   st_d.tsc = reg_wdata_i;
                ADDR_IADDR: st_d.ia  = reg_wdata_i;
                ADDR_IDATA: st_d.ind[st_q.ia[3:0]] = reg_wdata_i;
                default:
                begin
                    if (reg_addr_i >= ADDR_ORD0 && reg_addr_i <= ADDR_ORD7)
                        st_d.ord[3'(reg_addr_i - ADDR_ORD0)] = reg_wdata_i;
                end
            endcase
        end
        if (reg_read_i)
        begin
            unique case (reg_addr_i)
                ADDR_CTL:   st_d.rdata = st_q.ctl;
                ADDR_CFG:   st_d.rdata = st_q.cfg;
                ADDR_RED:   st_d.rdata = st_q.cr;
                ADDR_GRN:   st_d.rdata = st_q.cg;
                ADDR_BLU:   st_d.rdata = st_q.cb;
                ADDR_TSC:   st_d.rdata = st_q.tsc;
                ADDR_STAT:  st_d.rdata = {st_q.sidx, 1'b0, st_q.vb_done, tick, active};
                ADDR_IADDR: st_d.rdata = st_q.ia;
                ADDR_IDATA: st_d.rdata = st_q.ind[st_q.ia[3:0]];
                default:
                begin
                    if (reg_addr_i >= ADDR_ORD0 && reg_addr_i <= ADDR_ORD7)
                        st_d.rdata = st_q.ord[3'(reg_addr_i - ADDR_ORD0)];
                    else
                        st_d.rdata = REG_RST;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            st_q     <= '0;
            st_q.ctl <= CTL_RST;
            st_q.cfg <= REG_RST;
        end
        else
            st_q <= st_d;
    end

    assign reg_rdata_o       = st_q.rdata;
    assign pixel_stb_o       = st_q.stb;
    assign data_enable_o     = st_q.de2;
    assign horizontal_sync_o = st_q.hs2;
    assign vertical_sync_o   = st_q.vs2;
    assign red_o             = st_q.rgb2[23:16];
    assign green_o           = st_q.rgb2[15:8];
    assign blue_o            = st_q.rgb2[7:0];

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb_a @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    de_pipe_a:
    assert property (tick |=> st_q.de1 == $past(src_de) && st_q.hs1 == $past(src_hs) && st_q.vs1 == $past(src_vs))
        else $error("control stage one wrong");
    de_delay_a:
    assert property (tick && !power_down_i |=> data_enable_o == $past(st_q.de1) && vertical_sync_o == $past(st_q.vs1))
        else $error("control delay wrong");
    pix_src_a:
    assert property (tick && active |=> st_q.rgb1 == $past(pix))
        else $error("pattern not driven");
    low_bits_a:
    assert property (tick && active && st_q.cfg[CFG_B18] |=> (st_q.rgb1 & 24'h030303) == 24'h000000)
        else $error("18-bit low bits set");
    no_bars_a:
    assert property (scroll |-> cur_pat != PAT_BARS)
        else $error("bars in scroll");
    scroll_hold_a:
    assert property (!fe && scroll |=> $stable(st_q.sidx))
        else $error("scroll moved mid frame");
    scroll_wrap_a:
    assert property (fe && scroll && st_q.sidx >= st_q.tsc[3:0] |=> st_q.sidx == 4'h0)
        else $error("scroll did not wrap");
    vblank_run_a:
    assert property (tick && run_hit && !st_q.vb_done |=> st_q.y == 12'h000 && st_q.vb_done)
        else $error("blank run not frame end");
    ind_read_a:
    assert property (reg_read_i && reg_addr_i == ADDR_IDATA |=> reg_rdata_o == $past(st_q.ind[st_q.ia[3:0]]))
        else $error("indirect read wrong");
    pwr_down_a:
    assert property (power_down_i |=> !data_enable_o && red_o == 8'h00)
        else $error("outputs live in power down");
    scroll_c: cover property (fe && scroll && st_q.sidx != 4'h0);
    bars_c:   cover property (active && cur_pat == PAT_BARS && tick);
    run_c:    cover property (fe && run_hit);
endmodule

// ==== design/vtpg_pkg.sv ====
// register map, field layout and pattern codes of the video test pattern generator
// shared by the generator core and its testbench
package vtpg_pkg;
    // direct register offsets
    localparam logic [7:0] ADDR_CTL   = 8'h10;
    localparam logic [7:0] ADDR_CFG   = 8'h11;
    localparam logic [7:0] ADDR_RED   = 8'h12;
    localparam logic [7:0] ADDR_GRN   = 8'h13;
    localparam logic [7:0] ADDR_BLU   = 8'h14;
    localparam logic [7:0] ADDR_TSC   = 8'h15;
    localparam logic [7:0] ADDR_ORD0  = 8'h16;
    localparam logic [7:0] ADDR_ORD7  = 8'h1d;
    localparam logic [7:0] ADDR_STAT  = 8'h1e;
    localparam logic [7:0] ADDR_IADDR = 8'h66;
    localparam logic [7:0] ADDR_IDATA = 8'h67;

    // pattern_control fields
    localparam int CTL_PAT_HI = 4;
    localparam int CTL_INV    = 5;
    localparam int CTL_CKC    = 6;
    localparam int CTL_VCF    = 7;
    // pattern_config fields
    localparam int CFG_EN     = 0;
    localparam int CFG_B18    = 1;
    localparam int CFG_TM_LO  = 2;
    localparam int CFG_TM_HI  = 3;
    localparam int CFG_GINV   = 4;
    localparam int CFG_SCR    = 5;

    localparam logic [1:0] TM_EXT     = 2'h0;
    localparam logic [1:0] TM_INT_OSC = 2'h1;

    // reset values
    localparam logic [7:0] CTL_RST = 8'h01;
    localparam logic [7:0] REG_RST = 8'h00;

    // indirect space indices
    localparam logic [3:0] IX_HACT_LO = 4'h0;
    localparam logic [3:0] IX_HACT_HI = 4'h1;
    localparam logic [3:0] IX_VACT_LO = 4'h2;
    localparam logic [3:0] IX_VACT_HI = 4'h3;
    localparam logic [3:0] IX_HBLK    = 4'h4;
    localparam logic [3:0] IX_VBLK    = 4'h5;
    localparam logic [3:0] IX_HSW     = 4'h6;
    localparam logic [3:0] IX_VSW     = 4'h7;
    localparam logic [3:0] IX_OSC_DIV = 4'h8;

    // pattern codes
    localparam logic [4:0] PAT_WHITE   = 5'h01;
    localparam logic [4:0] PAT_RED     = 5'h03;
    localparam logic [4:0] PAT_GREEN   = 5'h04;
    localparam logic [4:0] PAT_BLUE    = 5'h05;
    localparam logic [4:0] PAT_HR_GRAY = 5'h06;
    localparam logic [4:0] PAT_HR_RED  = 5'h07;
    localparam logic [4:0] PAT_HR_GRN  = 5'h08;
    localparam logic [4:0] PAT_HR_BLU  = 5'h09;
    localparam logic [4:0] PAT_VR_GRAY = 5'h0a;
    localparam logic [4:0] PAT_VR_RED  = 5'h0b;
    localparam logic [4:0] PAT_VR_GRN  = 5'h0c;
    localparam logic [4:0] PAT_VR_BLU  = 5'h0d;
    localparam logic [4:0] PAT_CUSTOM  = 5'h0e;
    localparam logic [4:0] PAT_CHECK   = 5'h0f;
    localparam logic [4:0] PAT_VCOM    = 5'h10;
    localparam logic [4:0] PAT_BARS    = 5'h11;

    localparam logic [23:0] COL_WHITE = 24'hffffff;
    localparam logic [23:0] COL_BLACK = 24'h000000;
    localparam logic [7:0]  MASK_18   = 8'hfc;
    localparam int          CHK_BIT   = 4;
    localparam logic [14:0] BAR_COUNT = 15'h0008;
    localparam logic [19:0] RAMP_TOP  = 20'h000ff;
    // index 0 is the first bar at the left edge
    localparam logic [7:0][23:0] BAR_COLORS = {24'h000000, 24'h0000ff, 24'hff0000, 24'hff00ff,
                                               24'h00ff00, 24'h00ffff, 24'hffff00, 24'hffffff};
    localparam logic [3:0][23:0] VCOM_COLORS = {24'hff0000, 24'h0000ff, 24'h00ffff, 24'hffff00};
endpackage

// ==== verification/tb.sv ====
// testbench: drives registers and video pins of the pattern generator, checks its outputs
// assumes the package, the generator core and the video source model are compiled first
`timescale 1ns/1ps
module tb;
    import vtpg_pkg::*;
    logic        sys_clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        pwr_dn    = 1'b0;
    logic        run       = 1'b0;
    logic [7:0]  addr      = 8'h00;
    logic [7:0]  wdat      = 8'h00;
    logic        we        = 1'b0;
    logic        re        = 1'b0;
    logic        pclk, de, hs, vs, pixel_stb_o, data_enable_o, horizontal_sync_o, vertical_sync_o;
    logic [7:0]  pix, reg_rdata_o, red_o, green_o, blue_o;
    logic [2:0]  h2;
    logic [23:0] c;
    logic [23:0] frm [5];
    int          error_cnt    = 0;
    int          total_checks = 0;
    logic [23:0] sol  [5] = '{24'hffffff, 24'h000000, 24'hff0000, 24'h00ff00, 24'h0000ff};
    logic [23:0] bars [8] = '{24'hffffff, 24'hffff00, 24'h00ffff, 24'h00ff00,
                              24'hff00ff, 24'hff0000, 24'h0000ff, 24'h000000};
    // 32x2 active, 4/2 blanking, 1/1 sync, tick every second clock
    logic [7:0]  itab [9] = '{8'h20, 8'h00, 8'h02, 8'h00, 8'h04, 8'h02, 8'h01, 8'h01, 8'h01};
    logic [23:0] ln   [32];
    // reversed vcom order: red, blue, cyan, yellow
    logic [23:0] vcr  [4] = '{24'hff0000, 24'h0000ff, 24'h00ffff, 24'hffff00};

    always #5 sys_clk_i = ~sys_clk_i;

    video_source i_src (.run_i(run), .pixel_clk_o(pclk), .de_o(de), .hs_o(hs), .vs_o(vs),
                        .pix_o(pix), .ctl_h2_o(h2));
    video_test_pattern_generator i_dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .power_down_i(pwr_dn), .pixel_clk_i(pclk), .data_enable_i(de), .horizontal_sync_i(hs),
        .vertical_sync_i(vs), .red_i(pix), .green_i(pix), .blue_i(pix), .reg_addr_i(addr),
        .reg_wdata_i(wdat), .reg_write_i(we), .reg_read_i(re), .reg_rdata_o(reg_rdata_o),
        .pixel_stb_o(pixel_stb_o), .data_enable_o(data_enable_o),
        .horizontal_sync_o(horizontal_sync_o), .vertical_sync_o(vertical_sync_o),
        .red_o(red_o), .green_o(green_o), .blue_o(blue_o));

    // ----
    // access and compare tasks
    // ----
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks=%0d errors=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk_i);
        addr = a;
        wdat = d;
        we   = 1'b1;
        @(negedge sys_clk_i);
        we = 1'b0;
    endtask

    // read data holds until the next read, so one spare cycle is safe
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(negedge sys_clk_i);
        addr = a;
        re   = 1'b1;
        @(negedge sys_clk_i);
        re = 1'b0;
        @(negedge sys_clk_i);
        chk({16'h0, reg_rdata_o}, {16'h0, e});
    endtask

    // vsm: wait for output vsync, else for a pixel strobe with the given enable
    task automatic stb(input logic want, input logic vsm);
        int n;
        n = 0;
        do
        begin
            @(negedge sys_clk_i);
            n++;
        end
        while (!(vsm ? vertical_sync_o === 1'b1 : (pixel_stb_o === 1'b1 && data_enable_o === want))
               && n < 5000);
        if (n >= 5000)
        begin
            error_cnt++;
            stop_test();
        end
        c = {red_o, green_o, blue_o};
    endtask

    // two-stage pipe: the third active pixel shows the new setting
    task automatic pat(input logic [7:0] ctl, input logic [7:0] cfg, input logic [23:0] e);
        wr(ADDR_CTL, ctl);
        wr(ADDR_CFG, cfg);
        repeat (3) stb(1'b1, 1'b0);
        chk(c, e);
    endtask

    // one whole active line of a pattern, leftmost pixel first
    task automatic row(input logic [7:0] ctl);
        wr(ADDR_CTL, ctl);
        repeat (3) stb(1'b1, 1'b0);
        stb(1'b0, 1'b0);
        for (int i = 0; i < 32; i++)
        begin
            stb(1'b1, 1'b0);
            ln[i] = c;
        end
    endtask

    // ----
    // main sequence
    // ----
    initial
    begin
        repeat (5) @(negedge sys_clk_i);
        sys_rst_i = 1'b0;
        rdc(ADDR_CTL, 8'h01);
        rdc(ADDR_CFG, 8'h00);
        rdc(8'h00, 8'h00);
        for (int i = 0; i < 9; i++)
        begin
            wr(ADDR_IADDR, 8'(i));
            wr(ADDR_IDATA, itab[i]);
        end
        wr(ADDR_IADDR, 8'h04);
        rdc(ADDR_IDATA, 8'h04);
        rdc(ADDR_IADDR, 8'h04);
        // no source clock: internal oscillator timing only
        for (int p = 1; p <= 5; p++)
            pat(8'(p), 8'h05, sol[p - 1]);
        pat(8'h23, 8'h05, 24'h00ffff);
        pat(8'h03, 8'h15, 24'h00ffff);
        wr(ADDR_RED, 8'h57);
        wr(ADDR_GRN, 8'ha3);
        wr(ADDR_BLU, 8'h3e);
        pat(8'h0e, 8'h05, 24'h57a33e);
        pat(8'h0e, 8'h07, 24'h54a03c);
        wr(ADDR_CFG, 8'h05);
        row(8'h11);
        for (int i = 0; i < 32; i++)
            chk(ln[i], bars[i / 4]);
        row(8'h07);
        for (int i = 0; i < 32; i++)
            chk(ln[i], {8'(i * 255 / 32), 16'h0000});
        row(8'h4f);
        for (int i = 0; i < 32; i++)
            chk(ln[i], i < 16 ? 24'h000000 : 24'h57a33e);
        row(8'h90);
        for (int i = 0; i < 32; i++)
            chk(ln[i], vcr[i % 4]);
        pwr_dn = 1'b1;
        repeat (2) @(negedge sys_clk_i);
        chk({red_o, green_o, blue_o}, 24'h000000);
        chk({21'h0, data_enable_o, horizontal_sync_o, vertical_sync_o}, 24'h000000);
        pwr_dn = 1'b0;
        // pixel clock, then external timing, from the source model
        run = 1'b1;
        pat(8'h03, 8'h09, 24'hff0000);
        wr(ADDR_CFG, 8'h01);
        repeat (4) @(posedge pclk);
        for (int i = 0; i < 200; i++)
        begin
            @(posedge pclk);
            chk({21'h0, data_enable_o, horizontal_sync_o, vertical_sync_o}, {21'h0, h2});
        end
        wr(ADDR_TSC, 8'h01);
        wr(ADDR_ORD0, 8'h42);
        wr(ADDR_CFG, 8'h21);
        for (int f = 0; f < 5; f++)
        begin
            stb(1'b0, 1'b1);
            stb(1'b1, 1'b0);
            frm[f] = c;
        end
        for (int f = 2; f < 5; f++)
            chk(frm[f], frm[f - 1] === 24'hff0000 ? 24'h0000ff : 24'hff0000);
        stop_test();
    end
endmodule

// ==== verification/video_source.sv ====
// video source model: pixel clock, sync timing and pixel data for the generator pins
// assumes a 100 MHz system clock; the pixel clock is free-standing and stops when run_i is low
`timescale 1ns/1ps
module video_source (
    input  wire logic       run_i,
    output logic            pixel_clk_o,
    output logic            de_o,
    output logic            hs_o,
    output logic            vs_o,
    output logic      [7:0] pix_o,
    output logic      [2:0] ctl_h2_o
);
    // ----
    // frame of 16x6 pixels, 8x4 active
    // ----
    int         px = 0;
    logic [2:0] h1 = 3'h0;
    initial
    begin
        pixel_clk_o = 1'b0;
        ctl_h2_o    = 3'h0;
    end
    // 40 ns halves keep each phase above three system clocks
    always #40 pixel_clk_o = run_i ? ~pixel_clk_o : pixel_clk_o;
    assign de_o  = (px / 16 < 4) && (px % 16 < 8);
    assign hs_o  = (px % 16 >= 10) && (px % 16 < 12);
    assign vs_o  = (px / 16 == 4) && (px % 16 < 4);
    assign pix_o = 8'(px * 3);
    // launch on the falling edge so pins are steady at the rising edge
    always @(negedge pixel_clk_o) px <= (px + 1) % 96;
    // controls seen two rising edges ago, for the bench to compare
    always @(posedge pixel_clk_o)
    begin
        h1       <= {de_o, hs_o, vs_o};
        ctl_h2_o <= h1;
    end
endmodule
